// ### logic/dma_controller.sv
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/10ps
module dma_controller (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] ext_xfer_req_n,
	output logic [1:0] ext_xfer_grant_n,
	input wire logic uart_req,
	input wire logic [1:0] sio_req,
	input wire logic [1:0] timer_req,
	input wire logic refresh_req,
	input wire logic wbuf_req,
	input wire logic cpu_req,
	output logic refresh_grant,
	output logic wbuf_grant,
	output logic cpu_grant,
	output logic mem_req,
	output logic mem_write,
	output logic [26:0] mem_addr,
	output logic [1:0] mem_size,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_done,
	output logic [1:0] done_irq,
	output logic [1:0] stop_irq
);
	logic [1:0] rst_q;
	logic rst_n;
	logic [15:0] ctrl [0:1];
	logic [26:0] src [0:1];
	logic [26:0] dst [0:1];
	logic [26:0] cnt [0:1];
	logic [31:0] data [0:1];
	logic [1:0] beat [0:1];
	dma_pkg::ch_state_t state [0:1];
	dma_pkg::owner_t owner;
	dma_pkg::owner_t pick;
	logic [1:0] want, own, cyc_done, wr_done, last, busy, run, ready;
	logic [1:0] sw_wr, stop_now;
	logic hit, ch_sel, wr_en;
	logic [3:0] off;

	function automatic logic src_ok(input logic [1:0] m, input logic ext_n, input logic u, input logic o);
		case (m)
			dma_pkg::MODE_SW: src_ok = 1'b1;
			dma_pkg::MODE_EXT: src_ok = !ext_n;
			dma_pkg::MODE_UART: src_ok = u;
			default: src_ok = o;
		endcase
	endfunction

	function automatic logic [26:0] step(input logic [26:0] a, input logic down, input logic hold,
		input logic [1:0] tw);
		logic [26:0] inc;
		inc = (tw == dma_pkg::TW_WORD) ? dma_pkg::INC_WORD :
			(tw == dma_pkg::TW_HALF) ? dma_pkg::INC_HALF : dma_pkg::INC_BYTE;
		if (hold)
			step = a;
		else if (down)
			step = a - inc;
		else
			step = a + inc;
	endfunction

	////////////////////////////////////////////////////////////////
	// Reset release
	always_ff @(posedge mclk or negedge resetn) begin
		if (!resetn)
			rst_q <= 2'h0;
		else
			rst_q <= {rst_q[0], 1'b1};
	end
	assign rst_n = rst_q[1];

	////////////////////////////////////////////////////////////////
	// APB decode
	assign ch_sel = (paddr[15:4] == dma_pkg::CH1_BASE[15:4]);
	assign off = paddr[3:0];
	assign hit = ((paddr[15:4] == dma_pkg::CH0_BASE[15:4]) || ch_sel) && (off[1:0] == 2'h0);
	assign pready = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign wr_en = psel && penable && pwrite && hit;

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			sw_wr[i] = wr_en && (ch_sel == i[0]) && (off == dma_pkg::OFF_CTRL);
			run[i] = ctrl[i][dma_pkg::RUN_BIT];
			busy[i] = (state[i] != dma_pkg::ST_IDLE) || (run[i] && cnt[i] != '0);
			stop_now[i] = sw_wr[i] && !pwdata[dma_pkg::RUN_BIT] && busy[i];
			ready[i] = src_ok(ctrl[i][dma_pkg::MODE_LO +: 2], ext_xfer_req_n[i], uart_req,
				|sio_req || |timer_req);
			want[i] = (state[i] == dma_pkg::ST_READ) || (state[i] == dma_pkg::ST_WRITE);
			own[i] = (owner == (i == 0 ? dma_pkg::OWN_CH0 : dma_pkg::OWN_CH1));
			cyc_done[i] = own[i] && mem_done;
			wr_done[i] = cyc_done[i] && (state[i] == dma_pkg::ST_WRITE);
			last[i] = !(ctrl[i][dma_pkg::BT_BIT] && !ctrl[i][dma_pkg::CM_BIT]) || beat[i] == dma_pkg::BEAT_LAST;
		end
	end

	// Read data is latched in the setup phase so pready can stay high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			prdata <= 32'h00000000;
		else if (psel && !penable && !hit) begin
			prdata <= 32'h00000000;
		end else if (psel && !penable) begin
			prdata <= 32'h00000000;
			case (off)
				dma_pkg::OFF_SRC: prdata <= {5'h00, src[ch_sel]};
				dma_pkg::OFF_DST: prdata <= {5'h00, dst[ch_sel]};
				dma_pkg::OFF_CNT: prdata <= {5'h00, cnt[ch_sel]};
				dma_pkg::OFF_CTRL: prdata <= {16'h0000, ctrl[ch_sel][15:2], busy[ch_sel], run[ch_sel]};
				default: prdata <= 32'h00000000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// Channel registers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++)
				ctrl[i] <= dma_pkg::CTRL_RST;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (sw_wr[i])
					ctrl[i] <= pwdata[15:0] & dma_pkg::CTRL_WMASK;
				else if (wr_done[i] && last[i] && cnt[i] == dma_pkg::CNT_ONE)
					ctrl[i][dma_pkg::RUN_BIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				src[i] <= dma_pkg::ADDR_RST;
				dst[i] <= dma_pkg::ADDR_RST;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_en && ch_sel == i[0] && off == dma_pkg::OFF_SRC)
					src[i] <= pwdata[26:0];
				else if (wr_done[i])
					src[i] <= step(src[i], ctrl[i][dma_pkg::SD_BIT], ctrl[i][dma_pkg::SF_BIT],
						ctrl[i][dma_pkg::TW_LO +: 2]);
				if (wr_en && ch_sel == i[0] && off == dma_pkg::OFF_DST)
					dst[i] <= pwdata[26:0];
				else if (wr_done[i])
					dst[i] <= step(dst[i], ctrl[i][dma_pkg::DD_BIT], ctrl[i][dma_pkg::DF_BIT],
						ctrl[i][dma_pkg::TW_LO +: 2]);
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++)
				cnt[i] <= dma_pkg::ADDR_RST;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (wr_en && ch_sel == i[0] && off == dma_pkg::OFF_CNT)
					cnt[i] <= pwdata[26:0];
				else if (wr_done[i] && last[i])
					cnt[i] <= cnt[i] - dma_pkg::CNT_ONE;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++) begin
				data[i] <= 32'h00000000;
				beat[i] <= 2'h0;
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (cyc_done[i] && state[i] == dma_pkg::ST_READ)
					data[i] <= mem_rdata;
				if (wr_done[i])
					beat[i] <= last[i] ? 2'h0 : beat[i] + 2'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Channel sequencers
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < 2; i++)
				state[i] <= dma_pkg::ST_IDLE;
		end else begin
			for (int i = 0; i < 2; i++) begin
				case (state[i])
					dma_pkg::ST_IDLE:
						if (run[i] && cnt[i] != '0 && ready[i])
							state[i] <= dma_pkg::ST_READ;
					dma_pkg::ST_READ:
						if (cyc_done[i])
							state[i] <= run[i] ? dma_pkg::ST_GAP : dma_pkg::ST_IDLE;
						else if (!run[i] && !own[i])
							state[i] <= dma_pkg::ST_IDLE;
					dma_pkg::ST_GAP:
						if (!run[i])
							state[i] <= dma_pkg::ST_IDLE;
						else if (ctrl[i][dma_pkg::MODE_LO +: 2] != dma_pkg::MODE_EXT || !ext_xfer_req_n[i])
							state[i] <= dma_pkg::ST_WRITE;
					dma_pkg::ST_WRITE:
						if (wr_done[i])
							state[i] <= (!last[i] && run[i]) ? dma_pkg::ST_READ : dma_pkg::ST_IDLE;
						else if (!run[i] && !own[i])
							state[i] <= dma_pkg::ST_IDLE;
					default:
						state[i] <= dma_pkg::ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			done_irq <= 2'h0;
			stop_irq <= 2'h0;
		end else begin
			for (int i = 0; i < 2; i++) begin
				done_irq[i] <= wr_done[i] && last[i] && cnt[i] == dma_pkg::CNT_ONE;
				stop_irq[i] <= stop_now[i] && ctrl[i][dma_pkg::SI_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Bus arbiter and bus cycle
	always_comb begin
		if (refresh_req)
			pick = dma_pkg::OWN_REF;
		else if (want[0])
			pick = dma_pkg::OWN_CH0;
		else if (want[1])
			pick = dma_pkg::OWN_CH1;
		else if (wbuf_req)
			pick = dma_pkg::OWN_WBUF;
		else if (cpu_req)
			pick = dma_pkg::OWN_CPU;
		else
			pick = dma_pkg::OWN_NONE;
	end

	// A channel gives the bus back after every cycle, so others win between read and write
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n)
			owner <= dma_pkg::OWN_NONE;
		else begin
			case (owner)
				dma_pkg::OWN_NONE: owner <= pick;
				dma_pkg::OWN_CH0, dma_pkg::OWN_CH1:
					if (mem_done)
						owner <= dma_pkg::OWN_NONE;
				dma_pkg::OWN_REF:
					if (!refresh_req)
						owner <= dma_pkg::OWN_NONE;
				dma_pkg::OWN_WBUF:
					if (!wbuf_req)
						owner <= dma_pkg::OWN_NONE;
				dma_pkg::OWN_CPU:
					if (!cpu_req)
						owner <= dma_pkg::OWN_NONE;
				default: owner <= dma_pkg::OWN_NONE;
			endcase
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mem_addr <= dma_pkg::ADDR_RST;
			mem_write <= 1'b0;
			mem_size <= 2'h0;
			mem_wdata <= 32'h00000000;
		end else if (owner == dma_pkg::OWN_NONE && (pick == dma_pkg::OWN_CH0 || pick == dma_pkg::OWN_CH1)) begin
			mem_write <= state[pick == dma_pkg::OWN_CH1] == dma_pkg::ST_WRITE;
			mem_addr <= state[pick == dma_pkg::OWN_CH1] == dma_pkg::ST_WRITE ?
				dst[pick == dma_pkg::OWN_CH1] : src[pick == dma_pkg::OWN_CH1];
			mem_size <= ctrl[pick == dma_pkg::OWN_CH1][dma_pkg::TW_LO +: 2];
			mem_wdata <= data[pick == dma_pkg::OWN_CH1];
		end
	end

	assign mem_req = own[0] || own[1];
	assign ext_xfer_grant_n = ~own;
	assign refresh_grant = owner == dma_pkg::OWN_REF;
	assign wbuf_grant = owner == dma_pkg::OWN_WBUF;
	assign cpu_grant = owner == dma_pkg::OWN_CPU;

	////////////////////////////////////////////////////////////////
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	ch1_priority_a: assert property ($rose(own[1]) |-> !$past(want[0]) && !$past(refresh_req))
		else $error("channel 1 granted over higher request");
	refresh_first_a: assert property (owner == dma_pkg::OWN_NONE && refresh_req |=> refresh_grant)
		else $error("refresh not granted first");
	ack_cycle_a: assert property (!ext_xfer_grant_n[0] |-> want[0])
		else $error("acknowledge low outside a bus cycle");
	ack_rise_a: assert property (cyc_done[0] && state[0] == dma_pkg::ST_READ |=> ext_xfer_grant_n[0])
		else $error("acknowledge not raised after read");
	write_wait_a: assert property (state[0] == dma_pkg::ST_GAP && ext_xfer_req_n[0]
		&& ctrl[0][dma_pkg::MODE_LO +: 2] == dma_pkg::MODE_EXT |=> state[0] != dma_pkg::ST_WRITE)
		else $error("write started without request");
	count_step_a: assert property (wr_done[0] && last[0] && !(wr_en && !ch_sel)
		|=> cnt[0] == $past(cnt[0]) - dma_pkg::CNT_ONE)
		else $error("count did not drop by one");
	done_idle_a: assert property (done_irq[0] |-> !run[0] && cnt[0] == '0 && state[0] == dma_pkg::ST_IDLE)
		else $error("done without idle channel");
	stop_silent_a: assert property (stop_irq[0] |-> $past(ctrl[0][dma_pkg::SI_BIT]) && !run[0])
		else $error("stop interrupt while disabled");
	bus_dir_a: assert property (own[1] |-> mem_write == (state[1] == dma_pkg::ST_WRITE))
		else $error("bus cycle direction does not match phase");
endmodule

// ### logic/dma_pkg.sv
package dma_pkg;
	localparam int AW = 27;
	localparam logic [15:0] CH0_BASE = 16'h3000;
	localparam logic [15:0] CH1_BASE = 16'h4000;
	localparam logic [3:0] OFF_SRC = 4'h0;
	localparam logic [3:0] OFF_DST = 4'h4;
	localparam logic [3:0] OFF_CNT = 4'h8;
	localparam logic [3:0] OFF_CTRL = 4'hC;
	localparam int RUN_BIT = 0;
	localparam int BUSY_BIT = 1;
	localparam int MODE_LO = 2;
	localparam int DD_BIT = 4;
	localparam int SD_BIT = 5;
	localparam int DF_BIT = 6;
	localparam int SF_BIT = 7;
	localparam int SI_BIT = 8;
	localparam int BT_BIT = 9;
	localparam int TW_LO = 12;
	localparam int CM_BIT = 14;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'hFBFD;
	localparam logic [26:0] ADDR_RST = 27'h0000000;
	localparam logic [26:0] CNT_ONE = 27'h0000001;
	localparam logic [1:0] MODE_SW = 2'h0;
	localparam logic [1:0] MODE_EXT = 2'h1;
	localparam logic [1:0] MODE_UART = 2'h2;
	localparam logic [1:0] TW_HALF = 2'h1;
	localparam logic [1:0] TW_WORD = 2'h2;
	localparam logic [26:0] INC_BYTE = 27'h0000001;
	localparam logic [26:0] INC_HALF = 27'h0000002;
	localparam logic [26:0] INC_WORD = 27'h0000004;
	localparam logic [1:0] BEAT_LAST = 2'h3;
	typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_READ = 2'h1, ST_GAP = 2'h3, ST_WRITE = 2'h2} ch_state_t;
	typedef enum logic [2:0] {
		OWN_NONE = 3'h0, OWN_REF = 3'h1, OWN_CH0 = 3'h3, OWN_CH1 = 3'h2, OWN_WBUF = 3'h6, OWN_CPU = 3'h7
	} owner_t;
endpackage

// ### tb/mem_model.sv
`timescale 1ns/10ps
module mem_model (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic [4:0] delay,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [26:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic [31:0] mem_rdata,
	output logic mem_done,
	output logic [7:0] wcount
);
	logic [31:0] mem [0:255];
	logic [4:0] wait_cnt;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 32'hA5000000 + 32'(i);
		end
	end
	// Read data is only valid on the ending edge; otherwise it toggles
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mem_done <= 1'b0;
			wait_cnt <= 5'h00;
			wcount <= 8'h00;
			mem_rdata <= 32'h5A5A5A5A;
		end else begin
			mem_rdata <= ~mem_rdata;
			mem_done <= 1'b0;
			if (mem_req && !mem_done) begin
				wait_cnt <= wait_cnt + 5'h01;
				if (wait_cnt == delay) begin
					wait_cnt <= 5'h00;
					mem_done <= 1'b1;
					if (mem_write) begin
						mem[mem_addr[9:2]] <= mem_wdata;
						wcount <= wcount + 8'h01;
					end else begin
						mem_rdata <= mem[mem_addr[9:2]];
					end
				end
			end
		end
	end
endmodule

// ### tb/tb_two_channel_dma_controller.sv
`timescale 1ns/10ps
module tb_two_channel_dma_controller;
	logic mclk, resetn, psel, penable, pwrite, pready, pslverr, uart_req, refresh_req, wbuf_req, cpu_req;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, mem_wdata, mem_rdata, q;
	logic [1:0] ext_xfer_req_n, ext_xfer_grant_n, sio_req, timer_req, mem_size, done_irq, stop_irq;
	logic refresh_grant, wbuf_grant, cpu_grant, mem_req, mem_write, mem_done, e, ack_prev;
	logic [26:0] mem_addr;
	logic [4:0] delay;
	logic [7:0] wcount, w0;
	int err_count, n_tests, n_done0, n_stop0, n_ack1, k, d0;
	dma_controller i_dut (.mclk(mclk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_xfer_req_n(ext_xfer_req_n), .ext_xfer_grant_n(ext_xfer_grant_n), .uart_req(uart_req),
		.sio_req(sio_req), .timer_req(timer_req), .refresh_req(refresh_req), .wbuf_req(wbuf_req),
		.cpu_req(cpu_req), .refresh_grant(refresh_grant), .wbuf_grant(wbuf_grant), .cpu_grant(cpu_grant),
		.mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_size(mem_size),
		.mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done), .done_irq(done_irq),
		.stop_irq(stop_irq));
	mem_model i_mem (.mclk(mclk), .resetn(resetn), .delay(delay), .mem_req(mem_req), .mem_write(mem_write),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_done(mem_done), .wcount(wcount));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		n_done0 <= n_done0 + int'(done_irq[0]);
		n_stop0 <= n_stop0 + int'(stop_irq[0]);
		ack_prev <= ext_xfer_grant_n[1];
		n_ack1 <= n_ack1 + int'(ack_prev && !ext_xfer_grant_n[1]);
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic er);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1) @(posedge mclk);
		r = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic er;
		apb(1'b1, a, d, r, er);
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] r);
		logic er;
		apb(1'b0, a, 32'h00000000, r, er);
	endtask
	function automatic logic [15:0] ra(input int ch, input logic [3:0] off);
		return (ch == 1 ? dma_pkg::CH1_BASE : dma_pkg::CH0_BASE) | {12'h000, off};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("BAD %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic prog(input int ch, input logic [31:0] s, input logic [31:0] d, input logic [31:0] c,
		input logic [31:0] ctl);
		wr(ra(ch, dma_pkg::OFF_SRC), s);
		wr(ra(ch, dma_pkg::OFF_DST), d);
		wr(ra(ch, dma_pkg::OFF_CNT), c);
		wr(ra(ch, dma_pkg::OFF_CTRL), ctl);
	endtask
	task automatic wait_idle(input int ch);
		q = 32'h00000002;
		k = 0;
		while (q[1] !== 1'b0 && k < 3000) begin
			rd(ra(ch, dma_pkg::OFF_CTRL), q);
			k++;
		end
		chk(q & 32'h00000002, 32'h00000000);
	endtask
	task automatic wait_ack(input logic lvl);
		k = 0;
		while (ext_xfer_grant_n[1] !== lvl && k < 200) begin
			@(posedge mclk);
			k++;
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#600000;
		err_count++;
		final_report();
	end
	initial begin
		{resetn, psel, penable, pwrite, uart_req, refresh_req, wbuf_req, cpu_req, ack_prev} = 9'h001;
		{paddr, pwdata, sio_req, timer_req, delay} = 57'h0;
		{ext_xfer_req_n, err_count, n_tests, n_done0, n_stop0, n_ack1} = {2'b11, 160'h0};
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		repeat (3) @(posedge mclk);
		rd(ra(1, dma_pkg::OFF_CTRL), q);
		chk(q, {16'h0000, dma_pkg::CTRL_RST});
		rd(ra(1, dma_pkg::OFF_SRC), q);
		chk(q, 32'h00000000);
		apb(1'b0, 16'h3010, 32'h00000000, q, e);
		chk({31'h0, e}, 32'h00000001);
		chk(q, 32'h00000000);
		wr(ra(0, dma_pkg::OFF_CTRL), 32'h00000002);
		rd(ra(0, dma_pkg::OFF_CTRL), q);
		chk(q, 32'h00000000);
		$display("test registers done");
		for (int t = 0; t < 3; t++) begin
			prog(0, 32'h00000100, 32'h00000200, 32'h00000002, {18'h0, t[1:0], 12'h001});
			wait_idle(0);
			chk(q, {18'h0, t[1:0], 12'h000});
			rd(ra(0, dma_pkg::OFF_SRC), q);
			chk(q, 32'h00000100 + (32'h2 << t));
			rd(ra(0, dma_pkg::OFF_CNT), q);
			chk(q, 32'h00000000);
			chk(n_done0, t + 1);
		end
		chk(i_mem.mem[129], i_mem.mem[65]);
		prog(1, 32'h00000040, 32'h000000C0, 32'h00000003, 32'h00002061);
		wait_idle(1);
		rd(ra(1, dma_pkg::OFF_SRC), q);
		chk(q, 32'h00000034);
		rd(ra(1, dma_pkg::OFF_DST), q);
		chk(q, 32'h000000C0);
		chk(i_mem.mem[48], i_mem.mem[14]);
		$display("test sizes and directions done");
		delay <= 5'h0A;
		prog(0, 32'h00000000, 32'h00000300, 32'h00000028, 32'h00002101);
		repeat (60) @(posedge mclk);
		wr(ra(0, dma_pkg::OFF_CTRL), 32'h00002100);
		wait_idle(0);
		chk(n_stop0, 1);
		rd(ra(0, dma_pkg::OFF_CNT), q);
		chk({31'h0, q > 0 && q < 40}, 32'h00000001);
		wr(ra(0, dma_pkg::OFF_CTRL), 32'h00002101);
		wait_idle(0);
		chk(n_done0, 4);
		prog(0, 32'h00000000, 32'h00000300, 32'h00000028, 32'h00002001);
		repeat (60) @(posedge mclk);
		wr(ra(0, dma_pkg::OFF_CTRL), 32'h00002000);
		wait_idle(0);
		chk(n_stop0, 1);
		delay <= 5'h00;
		$display("test stop and resume done");
		refresh_req <= 1'b1;
		cpu_req <= 1'b1;
		prog(0, 32'h00000010, 32'h00000280, 32'h00000001, 32'h00002001);
		repeat (10) @(posedge mclk);
		chk({29'h0, mem_req, refresh_grant, cpu_grant}, 32'h00000002);
		refresh_req <= 1'b0;
		for (k = 0; k < 20 && mem_req !== 1'b1; k++) @(posedge mclk);
		chk({30'h0, mem_req, cpu_grant}, 32'h00000002);
		for (k = 0; k < 200 && cpu_grant !== 1'b1; k++) @(posedge mclk);
		chk({31'h0, cpu_grant}, 32'h00000001);
		cpu_req <= 1'b0;
		wait_idle(0);
		$display("test priority done");
		prog(1, 32'h00000020, 32'h00000180, 32'h00000001, 32'h00002005);
		w0 = wcount;
		d0 = n_ack1;
		ext_xfer_req_n <= 2'b01;
		wait_ack(1'b0);
		ext_xfer_req_n <= 2'b11;
		wait_ack(1'b1);
		repeat (10) @(posedge mclk);
		chk({24'h0, wcount}, {24'h0, w0});
		ext_xfer_req_n <= 2'b01;
		wait_ack(1'b0);
		wait_ack(1'b1);
		ext_xfer_req_n <= 2'b11;
		wait_idle(1);
		chk(n_ack1 - d0, 2);
		chk(i_mem.mem[96], i_mem.mem[8]);
		$display("test single step done");
		d0 = n_done0;
		for (int m = 2; m < 4; m++) begin
			prog(0, 32'h00000010, 32'h00000280, 32'h00000001, 32'h00002001 | (m << 2));
			uart_req <= (m == 2);
			timer_req <= (m == 3) ? 2'b01 : 2'b00;
			wait_idle(0);
			uart_req <= 1'b0;
			timer_req <= 2'b00;
			chk(n_done0, d0 + m - 1);
		end
		$display("test peripheral starts done");
		final_report();
	end
endmodule
